// ===== ppl_port_pins.sv
/*
 * Pin logic for port 3, port 4 and the input-only port 5, with a classic
 * Wishbone register slave. Assumes peripherals, serial channels and the bus
 * controller drive the alternate lines synchronously to core_clk.
 */
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
// Notes on behaviour
// [RL1] Sixteen port 3 lines, each one alternate function
// [RL2] Unused alternate lines act as plain GPIO
// [RL3] Alternate inputs come from input latch
// [RL4] Ready line has extra direct pin path
// [RL5] Output direction loops latch into alternate input
// [RL6] Alternate output ANDed with output latch
// [RL7] Software sets output and latch one first
// [RL8] Idle alternate output rests high
// [RL9] Serial pins carry data or clock
// [RL10] Sixteen-bit bus forces byte-high-enable pin out
// [RL11] Byte-high-enable switch follows latched bus mode
// [RL12] Byte-high-enable disable releases pin to GPIO
// [RL13] Async serial: software sets receive pins input
// [RL14] Sync serial: software switches receive direction
// [RL15] Port 4 lines carry segment address bits
// [RL16] External bus forces port 4 to segment
// [RL17] Segmentation disable returns port 4 to GPIO
// [RL18] Port 5: ten input-only lines, readable
// [RL19] Port 5 bits above nine read zero
// [RL20] Writes to port 5 are discarded
// [RL21] Port 5 reads need no mode select
// [RL22] Direction one is output, reset input
// [RL23] Reset forces all pins input, undriven
`default_nettype none

module ppl_port_pins #(
    parameter int AW = 8
) (
    input  wire logic          core_clk,
    input  wire logic          nrst,
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [AW-1:0] wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    input  wire logic [15:0]   third_port_in,
    output logic      [15:0]   third_port_out,
    output logic      [15:0]   third_port_oe,
    input  wire logic [1:0]    fourth_port_in,
    output logic      [1:0]    fourth_port_out,
    output logic      [1:0]    fourth_port_oe,
    input  wire logic [9:0]    analog_shared_input_port,
    input  wire logic          bus_config_pin0,
    input  wire logic          bus_config_pin1,
    input  wire logic [15:0]   alt_out_en,
    input  wire logic          timer6_toggle_out,
    input  wire logic          timer3_toggle_out,
    input  wire logic          serial1_transmit_pin,
    input  wire logic          serial1_receive_pin,
    input  wire logic          serial0_transmit_pin,
    input  wire logic          serial0_receive_pin,
    input  wire logic          byte_high_enable_n,
    input  wire logic          write_strobe_n,
    input  wire logic          system_clock_pin,
    input  wire logic          segment_addr_low,
    input  wire logic          segment_addr_high,
    output logic               timer0_count_in,
    output logic               capture_reload_trigger_in,
    output logic               timer3_updown_in,
    output logic               timer4_aux_in,
    output logic               timer3_count_in,
    output logic               timer2_aux_in,
    output logic               serial1_rx_in,
    output logic               serial0_rx_in,
    output logic               ready_latched_in,
    output logic               ready_direct_in,
    output logic               byte_high_enable_forced,
    output logic               segment_forced
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0] p3_latch;
        logic [15:0] p3_dir;
        logic [15:0] p3_in;
        logic [15:0] p3_out;
        logic [15:0] p3_oe;
        logic        rdy_direct;
        logic [1:0]  p4_latch;
        logic [1:0]  p4_dir;
        logic [1:0]  p4_in;
        logic [1:0]  p4_out;
        logic [1:0]  p4_oe;
        logic [9:0]  p5_in;
        logic        byte_high_enable_disable;
        logic        segmentation_disable;
        logic [1:0]  bus_mode;
        logic        mode_valid;
        logic        bhe_force;
        logic        seg_force;
        logic        ack;
        logic [31:0] rdata;
    } ppl_state_t;

    ppl_state_t st_q;
    ppl_state_t st_d;

    logic [15:0] alt_eff;
    logic [15:0] p3_out_d;
    logic [15:0] p3_oe_d;
    logic [15:0] p3_force;
    logic [15:0] p3_fval;
    logic [1:0]  p4_out_d;
    logic [1:0]  p4_oe_d;
    logic [1:0]  p4_force;
    logic        req;
    logic        wr;
    logic        bhe_force_d;
    logic        seg_force_d;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wdat[15:8];
        end
        return r;
    endfunction : merge16

    function automatic logic is_16bit(input logic [1:0] mode);
        return (mode == ppl_pkg::PPL_MODE_MUX16) || (mode == ppl_pkg::PPL_MODE_NONMUX16);
    endfunction : is_16bit

    // ****************************************************************
    // Alternate outputs, idle high when unused
    // ****************************************************************
    always_comb begin
        alt_eff = 16'hFFFF; // RL8
        alt_eff[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT] = ~alt_out_en[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT] | timer6_toggle_out;
        alt_eff[ppl_pkg::PPL_L_TIMER3_TOGGLE_OUT] = ~alt_out_en[ppl_pkg::PPL_L_TIMER3_TOGGLE_OUT] | timer3_toggle_out;
        alt_eff[ppl_pkg::PPL_L_TX1] = ~alt_out_en[ppl_pkg::PPL_L_TX1] | serial1_transmit_pin; // RL9
        alt_eff[ppl_pkg::PPL_L_RX1] = ~alt_out_en[ppl_pkg::PPL_L_RX1] | serial1_receive_pin; // RL9
        alt_eff[ppl_pkg::PPL_L_TX0] = ~alt_out_en[ppl_pkg::PPL_L_TX0] | serial0_transmit_pin; // RL9
        alt_eff[ppl_pkg::PPL_L_RX0] = ~alt_out_en[ppl_pkg::PPL_L_RX0] | serial0_receive_pin; // RL9
        alt_eff[ppl_pkg::PPL_L_WR] = ~alt_out_en[ppl_pkg::PPL_L_WR] | write_strobe_n;
        alt_eff[ppl_pkg::PPL_L_CLK] = ~alt_out_en[ppl_pkg::PPL_L_CLK] | system_clock_pin;
        p3_force = 16'h0000;
        p3_fval  = 16'h0000;
        p3_force[ppl_pkg::PPL_L_BHE] = st_q.bhe_force; // RL10
        p3_fval[ppl_pkg::PPL_L_BHE]  = byte_high_enable_n;
        p4_force = {2{st_q.seg_force}}; // RL16
    end

    // ****************************************************************
    // Pin cells
    // ****************************************************************
    ppl_pin_cell #(
        .W (16)
    ) u_p3_cell (
        .latch     (st_q.p3_latch),
        .dir       (st_q.p3_dir),
        .alt       (alt_eff),
        .force_sel (p3_force),
        .force_val (p3_fval),
        .force_oe  (p3_force),
        .out_d     (p3_out_d),
        .oe_d      (p3_oe_d)
    );

    ppl_pin_cell #(
        .W (2)
    ) u_p4_cell (
        .latch     (st_q.p4_latch),
        .dir       (st_q.p4_dir),
        .alt       (2'h3),
        .force_sel (2'h0),
        .force_val (2'h0),
        .force_oe  (p4_force),
        .out_d     (p4_out_d),
        .oe_d      (p4_oe_d)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        req  = wb_cyc_i & wb_stb_i & ~st_q.ack;
        wr   = req & wb_we_i;
        bhe_force_d = st_q.mode_valid & is_16bit(st_q.bus_mode) & ~st_q.byte_high_enable_disable; // RL11
        seg_force_d = st_q.mode_valid & (st_q.bus_mode != ppl_pkg::PPL_MODE_SINGLE)
                      & ~st_q.segmentation_disable;
        st_d.bhe_force = bhe_force_d;
        st_d.seg_force = seg_force_d;
        if (!st_q.mode_valid) begin
            st_d.bus_mode   = {bus_config_pin1, bus_config_pin0}; // RL11
            st_d.mode_valid = 1'b1;
        end
        st_d.p3_in      = third_port_in; // RL3 RL5
        st_d.rdy_direct = third_port_in[ppl_pkg::PPL_L_RDY]; // RL4
        st_d.p4_in      = fourth_port_in;
        st_d.p5_in      = analog_shared_input_port; // RL18 RL21
        st_d.p3_out     = p3_out_d;
        st_d.p3_oe      = p3_oe_d;
        st_d.p4_out     = p4_out_d;
        st_d.p4_oe      = p4_oe_d;
        st_d.ack        = req;
        if (wr) begin
            if (wb_adr_i == ppl_pkg::PPL_OFS_P3_LATCH) begin
                st_d.p3_latch = merge16(st_q.p3_latch, wb_dat_i, wb_sel_i);
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P3_DIR) begin
                st_d.p3_dir = merge16(st_q.p3_dir, wb_dat_i, wb_sel_i); // RL22
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P4_LATCH && wb_sel_i[0]) begin
                st_d.p4_latch = wb_dat_i[1:0];
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P4_DIR && wb_sel_i[0]) begin
                st_d.p4_dir = wb_dat_i[1:0];
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_SYSCFG && wb_sel_i[0]) begin
                st_d.byte_high_enable_disable = wb_dat_i[ppl_pkg::PPL_CFG_BYTE_HIGH_ENABLE_DISABLE_BIT]; // RL12
                st_d.segmentation_disable = wb_dat_i[ppl_pkg::PPL_CFG_SEGMENTATION_DISABLE_BIT]; // RL17
            end
        end
        if (st_q.seg_force) begin
            st_d.p4_latch = {segment_addr_high, segment_addr_low}; // RL15 RL16
        end
        if (req) begin
            st_d.rdata = 32'h0000_0000;
            if (wb_adr_i == ppl_pkg::PPL_OFS_P3_LATCH) begin
                st_d.rdata[15:0] = st_q.p3_latch;
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P3_DIR) begin
                st_d.rdata[15:0] = st_q.p3_dir;
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P3_IN) begin
                st_d.rdata[15:0] = st_q.p3_in;
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P4_LATCH) begin
                st_d.rdata[1:0] = st_q.p4_latch;
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P4_DIR) begin
                st_d.rdata[1:0] = st_q.p4_dir;
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P4_IN) begin
                st_d.rdata[1:0] = st_q.p4_in;
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_P5_IN) begin
                st_d.rdata[9:0] = st_q.p5_in; // RL19 RL20
            end else if (wb_adr_i == ppl_pkg::PPL_OFS_SYSCFG) begin
                st_d.rdata[ppl_pkg::PPL_CFG_BYTE_HIGH_ENABLE_DISABLE_BIT] = st_q.byte_high_enable_disable;
                st_d.rdata[ppl_pkg::PPL_CFG_SEGMENTATION_DISABLE_BIT] = st_q.segmentation_disable;
                st_d.rdata[ppl_pkg::PPL_CFG_MODE_LSB +: 2] = st_q.bus_mode;
                st_d.rdata[ppl_pkg::PPL_CFG_VALID_BIT] = st_q.mode_valid;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q          <= '0; // RL23
            st_q.p3_latch <= ppl_pkg::PPL_RST_P3_LATCH;
            st_q.p3_dir   <= ppl_pkg::PPL_RST_DIR16; // RL22 RL23
            st_q.p4_dir   <= ppl_pkg::PPL_RST_DIR2;
            st_q.byte_high_enable_disable   <= ppl_pkg::PPL_RST_DISABLE;
            st_q.segmentation_disable   <= ppl_pkg::PPL_RST_DISABLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign wb_dat_o                  = st_q.rdata;
    assign wb_ack_o                  = st_q.ack;
    assign third_port_out            = st_q.p3_out;
    assign third_port_oe             = st_q.p3_oe;
    assign fourth_port_out           = st_q.p4_out;
    assign fourth_port_oe            = st_q.p4_oe;
    assign timer0_count_in           = st_q.p3_in[ppl_pkg::PPL_L_TIMER0_COUNT_IN]; // RL1 RL3
    assign capture_reload_trigger_in = st_q.p3_in[ppl_pkg::PPL_L_CAPTURE_RELOAD_TRIGGER_IN];
    assign timer3_updown_in          = st_q.p3_in[ppl_pkg::PPL_L_T3UD];
    assign timer4_aux_in             = st_q.p3_in[ppl_pkg::PPL_L_TIMER4_AUX_IN];
    assign timer3_count_in           = st_q.p3_in[ppl_pkg::PPL_L_TIMER3_COUNT_IN];
    assign timer2_aux_in             = st_q.p3_in[ppl_pkg::PPL_L_TIMER2_AUX_IN];
    assign serial1_rx_in             = st_q.p3_in[ppl_pkg::PPL_L_RX1]; // RL9
    assign serial0_rx_in             = st_q.p3_in[ppl_pkg::PPL_L_RX0]; // RL9
    assign ready_latched_in          = st_q.p3_in[ppl_pkg::PPL_L_RDY];
    assign ready_direct_in           = st_q.rdy_direct; // RL4
    assign byte_high_enable_forced   = st_q.bhe_force;
    assign segment_forced            = st_q.seg_force;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence seg_latch_s;
        st_q.seg_force ##1 st_q.seg_force;
    endsequence

    a_gpio_line_drive: assert property (!alt_out_en[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT] // RL2
        |=> third_port_out[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT] == $past(st_q.p3_latch[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT])
            && third_port_oe[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT] == $past(st_q.p3_dir[ppl_pkg::PPL_L_TIMER6_TOGGLE_OUT]))
        else $error("GPIO line does not follow latch and direction");
    a_alt_and_latch: assert property (alt_out_en[ppl_pkg::PPL_L_TIMER3_TOGGLE_OUT] // RL6
        |=> third_port_out[ppl_pkg::PPL_L_TIMER3_TOGGLE_OUT] ==
            ($past(st_q.p3_latch[ppl_pkg::PPL_L_TIMER3_TOGGLE_OUT]) & $past(timer3_toggle_out)))
        else $error("Alternate output not ANDed with latch");
    a_alt_in_latch: assert property (1'b1 // RL3
        |=> timer0_count_in == $past(third_port_in[ppl_pkg::PPL_L_TIMER0_COUNT_IN]))
        else $error("Timer input not from input latch");
    a_ready_direct: assert property (1'b1 |=> ready_direct_in == $past(third_port_in[14])) // RL4
        else $error("Direct ready path wrong");
    a_bhe_forced: assert property (byte_high_enable_forced |=> third_port_oe[12] // RL10
        && third_port_out[12] == $past(byte_high_enable_n))
        else $error("Byte-high-enable pin not forced");
    a_bhe_mode: assert property (st_q.mode_valid && is_16bit(st_q.bus_mode) // RL11
        && !st_q.byte_high_enable_disable |=> byte_high_enable_forced)
        else $error("Byte-high-enable not switched by bus mode");
    a_bhe_release: assert property (st_q.mode_valid && st_q.byte_high_enable_disable ##1 st_q.byte_high_enable_disable // RL12
        |=> !byte_high_enable_forced ##0 third_port_oe[12] == $past(st_q.p3_dir[12]))
        else $error("Byte-high-enable not released to GPIO");
    a_seg_forced: assert property (seg_latch_s |=> fourth_port_oe == 2'h3 // RL16
        && fourth_port_out == $past({segment_addr_high, segment_addr_low}, 2))
        else $error("Segment address not driven on port 4");
    a_seg_release: assert property (!segment_forced // RL17
        |=> fourth_port_oe == $past(st_q.p4_dir))
        else $error("Port 4 not returned to GPIO");
    a_p5_upper_zero: assert property (req && !wb_we_i && wb_adr_i == ppl_pkg::PPL_OFS_P5_IN // RL19
        |=> wb_ack_o && wb_dat_o[31:10] == 22'h000000)
        else $error("Port 5 upper bits not zero");
    a_p5_write_none: assert property (wr && wb_adr_i == ppl_pkg::PPL_OFS_P5_IN // RL20
        |=> $stable(st_q.p3_latch) && $stable(st_q.p3_dir) && $stable(st_q.byte_high_enable_disable)
            && $stable(st_q.segmentation_disable) && $stable(st_q.p4_dir))
        else $error("Port 5 write had a side effect");
    a_reset_inputs: assert property (!st_q.mode_valid |-> third_port_oe == 16'h0000 // RL23
        && fourth_port_oe == 2'h0)
        else $error("Pins driven right after reset");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Ack longer than one cycle");

endmodule : ppl_port_pins

`default_nettype wire

// ===== ppl_pkg.sv
/*
 * Constants shared by the port 3/4/5 pin logic: register byte offsets,
 * field positions, reset values, line indices and bus mode codes.
 * Assumes a 32-bit classic Wishbone register bus with word-aligned offsets.
 */
`default_nettype none

package ppl_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] PPL_OFS_P3_LATCH = 8'h00;
    localparam logic [7:0] PPL_OFS_P3_DIR   = 8'h04;
    localparam logic [7:0] PPL_OFS_P3_IN    = 8'h08;
    localparam logic [7:0] PPL_OFS_P4_LATCH = 8'h0C;
    localparam logic [7:0] PPL_OFS_P4_DIR   = 8'h10;
    localparam logic [7:0] PPL_OFS_P4_IN    = 8'h14;
    localparam logic [7:0] PPL_OFS_P5_IN    = 8'h18;
    localparam logic [7:0] PPL_OFS_SYSCFG   = 8'h1C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int PPL_CFG_BYTE_HIGH_ENABLE_DISABLE_BIT = 0;
    localparam int PPL_CFG_SEGMENTATION_DISABLE_BIT = 1;
    localparam int PPL_CFG_MODE_LSB   = 2;
    localparam int PPL_CFG_VALID_BIT  = 4;
    localparam int PPL_P5_WIDTH       = 10;

    localparam logic [15:0] PPL_RST_P3_LATCH = 16'h0000;
    localparam logic [15:0] PPL_RST_DIR16    = 16'h0000;
    localparam logic [1:0]  PPL_RST_DIR2     = 2'h0;
    localparam logic        PPL_RST_DISABLE  = 1'b0;

    // ****************************************************************
    // Port 3 line indices
    // ****************************************************************
    localparam int PPL_L_TIMER0_COUNT_IN  = 0;
    localparam int PPL_L_TIMER6_TOGGLE_OUT = 1;
    localparam int PPL_L_CAPTURE_RELOAD_TRIGGER_IN = 2;
    localparam int PPL_L_TIMER3_TOGGLE_OUT = 3;
    localparam int PPL_L_T3UD  = 4;
    localparam int PPL_L_TIMER4_AUX_IN  = 5;
    localparam int PPL_L_TIMER3_COUNT_IN  = 6;
    localparam int PPL_L_TIMER2_AUX_IN  = 7;
    localparam int PPL_L_TX1   = 8;
    localparam int PPL_L_RX1   = 9;
    localparam int PPL_L_TX0   = 10;
    localparam int PPL_L_RX0   = 11;
    localparam int PPL_L_BHE   = 12;
    localparam int PPL_L_WR    = 13;
    localparam int PPL_L_RDY   = 14;
    localparam int PPL_L_CLK   = 15;

    // ****************************************************************
    // Bus modes latched from the bus configuration pins
    // ****************************************************************
    typedef enum logic [1:0] {
        PPL_MODE_SINGLE   = 2'h0,
        PPL_MODE_MUX8     = 2'h1,
        PPL_MODE_MUX16    = 2'h2,
        PPL_MODE_NONMUX16 = 2'h3
    } ppl_mode_t;

endpackage : ppl_pkg

`default_nettype wire

// ===== ppl_pin_cell.sv
/*
 * Combinational pin cell for a group of port lines: output value and
 * output enable from latch, direction, alternate output and hardware force.
 * Assumes the caller registers both results before they reach the pads.
 */
`default_nettype none

module ppl_pin_cell #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] latch,
    input  wire logic [W-1:0] dir,
    input  wire logic [W-1:0] alt,
    input  wire logic [W-1:0] force_sel,
    input  wire logic [W-1:0] force_val,
    input  wire logic [W-1:0] force_oe,
    output var  logic [W-1:0] out_d,
    output var  logic [W-1:0] oe_d
);

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    always_comb begin
        out_d = (force_sel & force_val) | (~force_sel & latch & alt); // RL6 RL10
        oe_d  = dir | force_oe; // RL2 RL22
    end

endmodule : ppl_pin_cell

`default_nettype wire

// ===== ppl_periph_model.sv
/* Model of the peripherals behind port 3/4: timers, serial channels and
   bus controller. Assumes the bench pulses advance to pick new values. */
`default_nettype none
module ppl_periph_model (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        advance,
    input  wire logic        active,
    output var  logic [15:0] alt_out_en,
    output var  logic [15:0] alt_val,
    output var  logic        bhe_n,
    output var  logic [1:0]  seg
);
    timeunit 1ns;
    timeprecision 1ns;
    integer      seed = 11;
    logic [15:0] raw_q;
    // ************
    // Alternate outputs
    // ************
    assign alt_val = raw_q | ~alt_out_en;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            alt_out_en <= 16'h0000;
            raw_q      <= 16'hFFFF;
            bhe_n      <= 1'b1;
            seg        <= 2'h0;
        end else if (advance) begin
            alt_out_en <= active ? (16'($random(seed)) & 16'hAF0A) : 16'h0000;
            raw_q      <= 16'($random(seed));
            bhe_n      <= 1'($random(seed));
            seg        <= 2'($random(seed));
        end
    end
endmodule : ppl_periph_model
`default_nettype wire

// ===== ppl_port_pins_tb.sv
/* Self-checking bench for the port 3/4/5 pin logic.
   Assumes the register map of ppl_pkg and one-cycle Wishbone answers. */
`default_nettype none
module ppl_port_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, nrst = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, adv = 1'b0, act = 1'b0;
    logic [3:0]  sel = 4'h3;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [15:0] p3_out, p3_oe, p3_ext = 16'h0, en, alt, p3_pad, lat, dir;
    logic [1:0]  p4_out, p4_oe, p4_ext = 2'h0, seg, strap = 2'h0, p4_pad, lat4, dir4;
    logic [9:0]  an = 10'h0;
    logic [8:0]  pin_in;
    logic        bhe_n, rdy_d, bhe_f, seg_f;
    integer      seed = 34662;
    int          miscompares = 0, n_tests = 0;
    assign p3_pad = (p3_oe & p3_out) | (~p3_oe & p3_ext);
    assign p4_pad = (p4_oe & p4_out) | (~p4_oe & p4_ext);
    always #50 core_clk = ~core_clk;
    ppl_port_pins ppl_port_pins_i (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .third_port_in(p3_pad), .third_port_out(p3_out),
        .third_port_oe(p3_oe), .fourth_port_in(p4_pad), .fourth_port_out(p4_out),
        .fourth_port_oe(p4_oe), .analog_shared_input_port(an), .bus_config_pin0(strap[0]),
        .bus_config_pin1(strap[1]), .alt_out_en(en), .timer6_toggle_out(alt[1]),
        .timer3_toggle_out(alt[3]), .serial1_transmit_pin(alt[8]),
        .serial1_receive_pin(alt[9]), .serial0_transmit_pin(alt[10]),
        .serial0_receive_pin(alt[11]), .byte_high_enable_n(bhe_n),
        .write_strobe_n(alt[13]), .system_clock_pin(alt[15]), .segment_addr_low(seg[0]),
        .segment_addr_high(seg[1]), .timer0_count_in(pin_in[0]),
        .capture_reload_trigger_in(pin_in[1]), .timer3_updown_in(pin_in[2]),
        .timer4_aux_in(pin_in[3]), .timer3_count_in(pin_in[4]), .timer2_aux_in(pin_in[5]),
        .serial1_rx_in(pin_in[6]), .serial0_rx_in(pin_in[7]), .ready_latched_in(pin_in[8]),
        .ready_direct_in(rdy_d), .byte_high_enable_forced(bhe_f), .segment_forced(seg_f));
    ppl_periph_model ppl_periph_model_i (.core_clk(core_clk), .nrst(nrst), .advance(adv),
        .active(act), .alt_out_en(en), .alt_val(alt), .bhe_n(bhe_n), .seg(seg));
    // ************
    // Tasks and expectations
    // ************
    function automatic logic [15:0] exp_p3(input logic [15:0] l, input logic [15:0] a);
        return l & (a | ~16'hAF0A);
    endfunction : exp_p3
    function automatic logic [8:0] exp_in(input logic [15:0] p);
        return {p[14], p[11], p[9], p[7], p[6], p[5], p[4], p[2], p[0]};
    endfunction : exp_in
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task step;
        adv <= 1'b1;
        @(posedge core_clk);
        adv <= 1'b0;
    endtask : step
    task test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    // ************
    // Main sequence
    // ************
    initial begin
        for (int m = 0; m < 4; m++) begin
            @(posedge core_clk);
            nrst <= 1'b0;
            strap <= 2'(m);
            repeat (16) @(posedge core_clk);
            chk(p3_oe, 16'h0000);
            nrst <= 1'b1;
            step();
            repeat (4) @(posedge core_clk);
            chk(bhe_f, m[1]);
            chk(seg_f, m != 0);
            if (m != 0) chk({p4_oe, p4_out}, {2'h3, seg});
            if (m > 1) chk({p3_oe[12], p3_out[12]}, {1'b1, bhe_n});
            wb(1'b0, 8'h04, 32'h0);
            chk(rdat, 32'h0);
            wb(1'b1, 8'h1C, 32'h3);
            wb(1'b0, 8'h1C, 32'h0);
            chk(rdat, 32'h13 | (m << 2));
            repeat (4) @(posedge core_clk);
            chk({bhe_f, seg_f, p3_oe[12], p4_oe}, 32'h0);
            $display("Bus mode test %0d done", m);
        end
        for (int i = 0; i < 24; i++) begin
            lat = 16'($random(seed));
            dir = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
            if (i == 0) lat = 16'hFFFF;
            lat4 = 2'($random(seed));
            dir4 = 2'($random(seed));
            act <= 1'($random(seed));
            p3_ext <= 16'($random(seed));
            p4_ext <= 2'($random(seed));
            an <= 10'($random(seed));
            step();
            wb(1'b1, 8'h00, 32'(lat));
            wb(1'b1, 8'h04, 32'(dir));
            wb(1'b1, 8'h0C, 32'(lat4));
            wb(1'b1, 8'h10, 32'(dir4));
            repeat (4) @(posedge core_clk);
            chk(p3_oe, dir);
            chk(p3_out & dir, exp_p3(lat, alt) & dir);
            chk(pin_in, exp_in(p3_pad));
            chk(rdy_d, p3_pad[14]);
            chk({p4_oe, p4_out & dir4}, {dir4, lat4 & dir4});
            wb(1'b0, 8'h08, 32'h0);
            chk(rdat, {16'h0, p3_pad});
            wb(1'b0, 8'h14, 32'h0);
            chk(rdat, {30'h0, p4_pad});
            wb(1'b1, 8'h18, $random(seed));
            wb(1'b0, 8'h18, 32'h0);
            chk(rdat, {22'h0, an});
            wb(1'b0, 8'h24, 32'h0);
            chk(rdat, 32'h0);
            $display("Pin test %0d done", i);
        end
        sel <= 4'h1;
        wb(1'b1, 8'h00, 32'h0000_5A5A);
        sel <= 4'h3;
        wb(1'b0, 8'h00, 32'h0);
        chk(rdat, {16'h0, lat[15:8], 8'h5A});
        $display("Byte lane test done");
        test_done();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        test_done();
    end
endmodule : ppl_port_pins_tb
`default_nettype wire
